// >>> logic/pic_regs.svh
// register offsets, field positions, reset values and rule summary for the ingress control bank
// Summary of operation
// - ceiling clamps user priority to default tag
// - discard-untagged bit drops frames without tag
// - discard-tagged bit drops frames with tag
// - unclassified frames take port default priority
// - acl enable reads back at bit two
// - block mode blocks acl misses
// - pass mode forwards acl misses
// - trap mode steers all traffic to host and blocks acl misses
// - port index field sits at bits 18:16
// - queue pointer field sits at bits 1:0
// - priority p maps through nibble p
// - upper two slot bits never steer queue
// - map resets to pairs onto queues 0..3
// - vlan, 802.1p, diffserv enables gate classifiers
`ifndef PIC_REGS_SVH
`define PIC_REGS_SVH
// register indices; byte address is four times the index
`define PIC_IDX_CLS_EN 14'h0801
`define PIC_IDX_TAG_CTRL 14'h0802
`define PIC_IDX_AUTH 14'h0803
`define PIC_IDX_PTR 14'h0804
`define PIC_IDX_MAP 14'h0808
// field positions
`define PIC_B_CEIL 7
`define PIC_B_DISC_UNTAG 4
`define PIC_B_DISC_TAG 3
`define PIC_B_VLAN_EN 3
`define PIC_B_DOT1P_EN 2
`define PIC_B_DSV_EN 1
`define PIC_B_ACL_EN 2
`define PIC_B_PORT_LO 16
`define PIC_B_QPTR_LO 0
// auth mode codes
`define PIC_AUTH_BLOCK 2'h1
`define PIC_AUTH_PASS 2'h2
`define PIC_AUTH_TRAP 2'h3
// reset values
`define PIC_RST_MAP 16'hfa50
`define PIC_RST_AUTH 2'h0
`define PIC_RST_DEF_PRI 3'h0
`endif

// >>> logic/pic_pkg.sv
// types shared by the ingress classify control bank
package pic_pkg;
    // bus handshake phase
    typedef enum logic [0:0] {
        PIC_IDLE = 1'b0,
        PIC_ACK = 1'b1
    } pic_bus_st_t;
    // whole state of the block
    typedef struct packed {
        pic_bus_st_t st;
        logic wait_r;
        logic [31:0] rdata;
        logic ceil;
        logic disc_untag;
        logic disc_tag;
        logic [2:0] def_pri;
        logic [1:0] auth;
        logic [2:0] port_idx;
        logic [1:0] q_ptr;
        logic [15:0] map;
        logic vlan_en;
        logic dot1p_en;
        logic dsv_en;
        logic o_valid;
        logic o_drop;
        logic [2:0] o_upri;
        logic [2:0] o_prio;
        logic [1:0] o_queue;
        logic o_host;
        logic o_acl;
    } pic_state_t;
endpackage

// >>> logic/pic_ingress_ctrl.sv
// ingress tag, priority, auth and queue map control with avalon slave
`timescale 1ns/10ps
`include "pic_regs.svh"
module pic_ingress_ctrl (
    // clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // avalon-mm slave, byte address
    input wire logic [15:0] ADDRESS,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic [3:0] BYTEENABLE,
    input wire logic [31:0] WRITEDATA,
    output logic [31:0] READDATA,
    output logic WAITREQUEST,
    // frame descriptor from ingress parser
    input wire logic FRM_VALID,
    input wire logic FRM_TAGGED,
    input wire logic [2:0] FRM_UPRI,
    input wire logic [2:0] DEF_TAG_UPRI,
    // classifier results
    input wire logic DSV_HIT,
    input wire logic [2:0] DSV_PRI,
    input wire logic VLAN_HIT,
    input wire logic [2:0] VLAN_PRI,
    // acl engine status
    input wire logic ACL_EN,
    input wire logic ACL_HIT,
    // classified frame decision
    output logic OUT_VALID,
    output logic OUT_DROP,
    output logic [2:0] OUT_UPRI,
    output logic [2:0] OUT_PRIO,
    output logic [1:0] OUT_QUEUE,
    output logic OUT_TO_HOST,
    output logic OUT_ACL_ACT,
    // indirect pointers for other per-port banks
    output logic [2:0] PORT_INDEX,
    output logic [1:0] QUEUE_PTR
);
    pic_pkg::pic_state_t s_reg; // current state
    pic_pkg::pic_state_t s_next; // next state
    logic [13:0] idx; // word index of the access
    logic [31:0] be_mask; // byte enable expanded to bits
    logic [31:0] map_rd; // map readback, upper slot bits zero
    logic [31:0] rd_val; // decoded read value
    logic [2:0] upri_c; // user priority after ceiling
    logic [2:0] prio_c; // classified priority
    logic miss_block; // acl miss that must be blocked

    assign idx = ADDRESS[15:2];

    // byte lanes to bit mask
    assign be_mask = {{8{BYTEENABLE[3]}}, {8{BYTEENABLE[2]}},
                      {8{BYTEENABLE[1]}}, {8{BYTEENABLE[0]}}};

    // each 4-bit slot reads back its 2-bit queue with zeros above
    genvar p;
    generate
        for (p = 0; p < 8; p++) begin : g_slot
            assign map_rd[4*p +: 4] = {2'h0, s_reg.map[2*p +: 2]};
        end
    endgenerate

    // read decode; unmapped words read zero
    always_comb begin
        rd_val = 32'h0;
        case (idx)
            `PIC_IDX_CLS_EN: begin
                rd_val[`PIC_B_VLAN_EN] = s_reg.vlan_en;
                rd_val[`PIC_B_DOT1P_EN] = s_reg.dot1p_en;
                rd_val[`PIC_B_DSV_EN] = s_reg.dsv_en;
            end
            `PIC_IDX_TAG_CTRL: begin
                rd_val[`PIC_B_CEIL] = s_reg.ceil;
                rd_val[`PIC_B_DISC_UNTAG] = s_reg.disc_untag;
                rd_val[`PIC_B_DISC_TAG] = s_reg.disc_tag;
                rd_val[2:0] = s_reg.def_pri;
            end
            `PIC_IDX_AUTH: begin
                rd_val[`PIC_B_ACL_EN] = ACL_EN;
                rd_val[1:0] = s_reg.auth;
            end
            `PIC_IDX_PTR: begin
                rd_val[`PIC_B_PORT_LO +: 3] = s_reg.port_idx;
                rd_val[`PIC_B_QPTR_LO +: 2] = s_reg.q_ptr;
            end
            `PIC_IDX_MAP: begin
                rd_val = map_rd;
            end
            default: begin
                rd_val = 32'h0;
            end
        endcase
    end

    // ceiling against the default tag priority from the DEF_TAG_UPRI input
    assign upri_c = (s_reg.ceil && (FRM_UPRI > DEF_TAG_UPRI)) ?
                    DEF_TAG_UPRI : FRM_UPRI;

    // classifier order: diffserv, then 802.1p, then vlan, then default
    always_comb begin
        if (s_reg.dsv_en && DSV_HIT) begin
            prio_c = DSV_PRI;
        end else if (s_reg.dot1p_en && FRM_TAGGED) begin
            prio_c = upri_c;
        end else if (s_reg.vlan_en && VLAN_HIT) begin
            prio_c = VLAN_PRI;
        end else begin
            prio_c = s_reg.def_pri;
        end
    end

    // block and trap turn acl misses away, pass and reserved code do not
    assign miss_block = ACL_EN && !ACL_HIT &&
                        ((s_reg.auth == `PIC_AUTH_BLOCK) ||
                         (s_reg.auth == `PIC_AUTH_TRAP));

    // next state for bus handshake, registers and frame decision
    always_comb begin
        s_next = s_reg;
        // bus: one idle cycle with waitrequest high, then one answer cycle
        case (s_reg.st)
            pic_pkg::PIC_IDLE: begin
                if (READ || WRITE) begin
                    s_next.st = pic_pkg::PIC_ACK;
                    s_next.wait_r = 1'b0;
                    s_next.rdata = READ ? rd_val : 32'h0;
                end
            end
            pic_pkg::PIC_ACK: begin
                s_next.st = pic_pkg::PIC_IDLE;
                s_next.wait_r = 1'b1;
                // write lands on the edge where master sees waitrequest low
                if (WRITE) begin
                    case (idx)
                        `PIC_IDX_CLS_EN: begin
                            if (BYTEENABLE[0]) begin
                                s_next.vlan_en = WRITEDATA[`PIC_B_VLAN_EN];
                                s_next.dot1p_en = WRITEDATA[`PIC_B_DOT1P_EN];
                                s_next.dsv_en = WRITEDATA[`PIC_B_DSV_EN];
                            end
                        end
                        `PIC_IDX_TAG_CTRL: begin
                            if (BYTEENABLE[0]) begin
                                s_next.ceil = WRITEDATA[`PIC_B_CEIL];
                                s_next.disc_untag = WRITEDATA[`PIC_B_DISC_UNTAG];
                                s_next.disc_tag = WRITEDATA[`PIC_B_DISC_TAG];
                                s_next.def_pri = WRITEDATA[2:0];
                            end
                        end
                        `PIC_IDX_AUTH: begin
                            // acl enable bit is read-only, ignored here
                            if (BYTEENABLE[0]) begin
                                s_next.auth = WRITEDATA[1:0];
                            end
                        end
                        `PIC_IDX_PTR: begin
                            if (BYTEENABLE[2]) begin
                                s_next.port_idx = WRITEDATA[`PIC_B_PORT_LO +: 3];
                            end
                            if (BYTEENABLE[0]) begin
                                s_next.q_ptr = WRITEDATA[`PIC_B_QPTR_LO +: 2];
                            end
                        end
                        `PIC_IDX_MAP: begin
                            // only the low two bits of each slot are kept
                            for (int i = 0; i < 8; i++) begin
                                if (be_mask[4*i]) begin
                                    s_next.map[2*i +: 2] = WRITEDATA[4*i +: 2];
                                end
                            end
                        end
                        default: begin
                            s_next.map = s_reg.map; // unmapped write ignored
                        end
                    endcase
                end
            end
            default: begin
                s_next.st = pic_pkg::PIC_IDLE;
                s_next.wait_r = 1'b1;
            end
        endcase
        // frame decision, one cycle after the descriptor
        s_next.o_valid = FRM_VALID;
        s_next.o_drop = (s_reg.disc_untag && !FRM_TAGGED) ||
                        (s_reg.disc_tag && FRM_TAGGED) || miss_block;
        s_next.o_upri = upri_c;
        s_next.o_prio = prio_c;
        s_next.o_queue = s_reg.map[2*prio_c +: 2];
        s_next.o_host = (s_reg.auth == `PIC_AUTH_TRAP);
        s_next.o_acl = ACL_EN && ACL_HIT; // matching frames take rule actions
    end

    // state register; map reset pairs priorities onto queues
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            s_reg <= '0;
            s_reg.st <= pic_pkg::PIC_IDLE;
            s_reg.wait_r <= 1'b1;
            s_reg.def_pri <= `PIC_RST_DEF_PRI;
            s_reg.auth <= `PIC_RST_AUTH;
            s_reg.map <= `PIC_RST_MAP;
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs straight from state flops
    assign READDATA = s_reg.rdata;
    assign WAITREQUEST = s_reg.wait_r;
    assign OUT_VALID = s_reg.o_valid;
    assign OUT_DROP = s_reg.o_drop;
    assign OUT_UPRI = s_reg.o_upri;
    assign OUT_PRIO = s_reg.o_prio;
    assign OUT_QUEUE = s_reg.o_queue;
    assign OUT_TO_HOST = s_reg.o_host;
    assign OUT_ACL_ACT = s_reg.o_acl;
    assign PORT_INDEX = s_reg.port_idx;
    assign QUEUE_PTR = s_reg.q_ptr;

    // checks on the decision path and register file
    AST_CEIL: assert property (@(posedge CLK) disable iff (SYS_RST)
        FRM_VALID && s_reg.ceil && (FRM_UPRI > DEF_TAG_UPRI) |=> OUT_UPRI == $past(DEF_TAG_UPRI))
        else $error("ceiling did not clamp user priority");
    AST_NO_CEIL: assert property (@(posedge CLK) disable iff (SYS_RST)
        FRM_VALID && !s_reg.ceil |=> OUT_UPRI == $past(FRM_UPRI))
        else $error("user priority changed with ceiling off");
    AST_DROP_UNTAG: assert property (@(posedge CLK) disable iff (SYS_RST)
        FRM_VALID && s_reg.disc_untag && !FRM_TAGGED |=> OUT_VALID && OUT_DROP)
        else $error("untagged frame not dropped");
    AST_DROP_TAG: assert property (@(posedge CLK) disable iff (SYS_RST)
        FRM_VALID && s_reg.disc_tag && FRM_TAGGED |=> OUT_DROP)
        else $error("tagged frame not dropped");
    AST_DEF_PRI: assert property (@(posedge CLK) disable iff (SYS_RST)
        FRM_VALID && !s_reg.dsv_en && !s_reg.dot1p_en && !s_reg.vlan_en
        |=> OUT_PRIO == $past(s_reg.def_pri))
        else $error("default priority not applied");
    AST_ACL_RD: assert property (@(posedge CLK) disable iff (SYS_RST)
        s_reg.st == pic_pkg::PIC_IDLE && READ && idx == `PIC_IDX_AUTH
        |=> READDATA[2] == $past(ACL_EN) && READDATA[7:3] == 5'h0)
        else $error("acl enable readback wrong");
    AST_BLOCK: assert property (@(posedge CLK) disable iff (SYS_RST)
        FRM_VALID && s_reg.auth == `PIC_AUTH_BLOCK && ACL_EN && !ACL_HIT |=> OUT_DROP)
        else $error("block mode let an acl miss through");
    AST_PASS: assert property (@(posedge CLK) disable iff (SYS_RST)
        FRM_VALID && s_reg.auth == `PIC_AUTH_PASS && !s_reg.disc_tag && !s_reg.disc_untag
        |=> !OUT_DROP && !OUT_TO_HOST)
        else $error("pass mode dropped or trapped a frame");
    AST_TRAP: assert property (@(posedge CLK) disable iff (SYS_RST)
        s_reg.auth == `PIC_AUTH_TRAP |=> OUT_TO_HOST)
        else $error("trap mode did not steer to host");
    AST_QUEUE: assert property (@(posedge CLK) disable iff (SYS_RST)
        FRM_VALID |=> OUT_QUEUE == $past(s_reg.map[2*prio_c +: 2]))
        else $error("queue does not follow map slot");
    AST_MAP_RD: assert property (@(posedge CLK) disable iff (SYS_RST)
        s_reg.st == pic_pkg::PIC_IDLE && READ && idx == `PIC_IDX_MAP
        |=> (READDATA & 32'hcccccccc) == 32'h0)
        else $error("reserved slot bits read nonzero");
    AST_PTR_WR: assert property (@(posedge CLK) disable iff (SYS_RST)
        s_reg.st == pic_pkg::PIC_ACK && WRITE && idx == `PIC_IDX_PTR && BYTEENABLE[2]
        |=> PORT_INDEX == $past(WRITEDATA[18:16]))
        else $error("port index write lost");
    AST_HSHAKE: assert property (@(posedge CLK) disable iff (SYS_RST)
        !WAITREQUEST |=> WAITREQUEST)
        else $error("waitrequest low for more than one cycle");

    // further checks; each antecedent is reached by random traffic
    // or by directed register accesses, so none holds only vacuously
    // frames with no discard cause and no acl miss must pass
    AST_KEEP: assert property (@(posedge CLK) disable iff (SYS_RST)
        FRM_VALID && !s_reg.disc_untag && !s_reg.disc_tag && !(ACL_EN && !ACL_HIT)
        |=> !OUT_DROP)
        else $error("frame dropped with no discard cause");
    // classifiers enabled but silent still fall back to the default
    AST_DEF_MISS: assert property (@(posedge CLK) disable iff (SYS_RST)
        FRM_VALID && !(s_reg.dsv_en && DSV_HIT) && !(s_reg.dot1p_en && FRM_TAGGED)
        && !(s_reg.vlan_en && VLAN_HIT)
        |=> OUT_PRIO == $past(s_reg.def_pri))
        else $error("default priority not applied on classifier miss");
    // diffserv hit wins over every other classifier
    AST_DSV: assert property (@(posedge CLK) disable iff (SYS_RST)
        FRM_VALID && s_reg.dsv_en && DSV_HIT |=> OUT_PRIO == $past(DSV_PRI))
        else $error("diffserv priority not taken");
    // matching frames carry the rule action flag in every mode
    AST_ACL_ACT: assert property (@(posedge CLK) disable iff (SYS_RST)
        FRM_VALID && ACL_EN && ACL_HIT |=> OUT_ACL_ACT)
        else $error("acl match lost its action flag");
    // only trap mode steers to the host
    AST_HOST_OFF: assert property (@(posedge CLK) disable iff (SYS_RST)
        s_reg.auth != `PIC_AUTH_TRAP |=> !OUT_TO_HOST)
        else $error("host steering outside trap mode");
    // auth mode write lands on the answer edge
    AST_AUTH_WR: assert property (@(posedge CLK) disable iff (SYS_RST)
        s_reg.st == pic_pkg::PIC_ACK && WRITE && idx == `PIC_IDX_AUTH && BYTEENABLE[0]
        |=> s_reg.auth == $past(WRITEDATA[1:0]))
        else $error("auth mode write lost");
    // queue pointer written through lane 0
    AST_QPTR_WR: assert property (@(posedge CLK) disable iff (SYS_RST)
        s_reg.st == pic_pkg::PIC_ACK && WRITE && idx == `PIC_IDX_PTR && BYTEENABLE[0]
        |=> QUEUE_PTR == $past(WRITEDATA[1:0]))
        else $error("queue pointer write lost");
    // slot zero keeps only its queue bits, whatever the reserved bits hold
    AST_MAP_WR: assert property (@(posedge CLK) disable iff (SYS_RST)
        s_reg.st == pic_pkg::PIC_ACK && WRITE && idx == `PIC_IDX_MAP && BYTEENABLE[0]
        |=> s_reg.map[1:0] == $past(WRITEDATA[1:0]))
        else $error("map slot zero write lost");
    // words past the map are unmapped and read as zero
    AST_UNMAP_RD: assert property (@(posedge CLK) disable iff (SYS_RST)
        s_reg.st == pic_pkg::PIC_IDLE && READ && idx > `PIC_IDX_MAP
        |=> READDATA == 32'h0)
        else $error("unmapped word read nonzero");
endmodule

// >>> tb/pic_pipe_model.sv
// ingress parser and classifier stand-in feeding frame descriptors
`timescale 1ns/10ps
module pic_pipe_model (
    // clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // traffic enable from the bench
    input wire logic go,
    // descriptor and classifier results, packed
    output logic frm_valid,
    output logic [15:0] fld
);
    integer seed = 31; // fixed seed keeps runs repeatable
    logic [31:0] r; // raw draw
    // one draw per cycle; fields flip while idle so stale values never look valid
    always @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            frm_valid <= 1'b0;
            fld <= 16'h0000;
        end else if (go) begin
            r = $random(seed);
            frm_valid <= r[16] | r[17]; // mostly back to back
            fld <= r[15:0];
        end else begin
            frm_valid <= 1'b0;
            fld <= ~fld;
        end
    end
endmodule

// >>> tb/tb_top.sv
// self-checking bench for the ingress classify control bank
`timescale 1ns/10ps
`include "pic_regs.svh"
module tb_top;
    logic CLK, SYS_RST, READ, WRITE, WAITREQUEST, go, acl_en, have;
    logic [15:0] ADDRESS, fld;
    logic [3:0] BYTEENABLE;
    logic [31:0] WRITEDATA, READDATA, d, mp;
    logic OUT_VALID, OUT_DROP, OUT_TO_HOST, OUT_ACL_ACT, frm_valid;
    logic [2:0] OUT_UPRI, OUT_PRIO, PORT_INDEX;
    logic [1:0] OUT_QUEUE, QUEUE_PTR, au;
    logic [7:0] tc, ce; // shadow of tag ctrl and class enable
    logic [10:0] ex;
    logic [11:0] g_frm, e_frm; // observed and expected decision
    logic [15:0] al [4];
    integer seed = 31;
    int fail_count, compares, cyc;
    localparam logic [15:0] A_CE = {`PIC_IDX_CLS_EN, 2'b00};
    localparam logic [15:0] A_TAG = {`PIC_IDX_TAG_CTRL, 2'b00};
    localparam logic [15:0] A_AUTH = {`PIC_IDX_AUTH, 2'b00};
    localparam logic [15:0] A_PTR = {`PIC_IDX_PTR, 2'b00};
    localparam logic [15:0] A_MAP = {`PIC_IDX_MAP, 2'b00};
    // 8 ns period
    always #4 CLK = ~CLK;
    pic_pipe_model model (.CLK(CLK), .SYS_RST(SYS_RST), .go(go), .frm_valid(frm_valid),
        .fld(fld));
    pic_ingress_ctrl dut (.CLK(CLK), .SYS_RST(SYS_RST), .ADDRESS(ADDRESS), .READ(READ),
        .WRITE(WRITE), .BYTEENABLE(BYTEENABLE), .WRITEDATA(WRITEDATA), .READDATA(READDATA),
        .WAITREQUEST(WAITREQUEST), .FRM_VALID(frm_valid), .FRM_TAGGED(fld[0]),
        .FRM_UPRI(fld[3:1]), .DEF_TAG_UPRI(fld[6:4]), .DSV_HIT(fld[7]), .DSV_PRI(fld[10:8]),
        .VLAN_HIT(fld[11]), .VLAN_PRI(fld[14:12]), .ACL_EN(acl_en), .ACL_HIT(fld[15]),
        .OUT_VALID(OUT_VALID), .OUT_DROP(OUT_DROP), .OUT_UPRI(OUT_UPRI), .OUT_PRIO(OUT_PRIO),
        .OUT_QUEUE(OUT_QUEUE), .OUT_TO_HOST(OUT_TO_HOST), .OUT_ACL_ACT(OUT_ACL_ACT),
        .PORT_INDEX(PORT_INDEX), .QUEUE_PTR(QUEUE_PTR));
    // verdict and stop
    task end_of_test;
        if (fail_count == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task chk_reg(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %0t reg got %h exp %h", $time, g, e);
        end
    endtask
    task chk_frm(input logic [11:0] g, input logic [11:0] e);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %0t frame got %h exp %h", $time, g, e);
        end
    endtask
    // bounded wait for the slave's one-cycle answer
    task wait_ack;
        int n;
        n = 0;
        do begin
            @(posedge CLK);
            n++;
        end while (WAITREQUEST !== 1'b0 && n < 50);
        if (n >= 50) begin
            fail_count++;
            $display("MISMATCH %0t bus hang", $time);
            end_of_test;
        end
    endtask
    // request held until waitrequest sampled low, released after that edge
    task bus_rd(input logic [15:0] a, output logic [31:0] q);
        ADDRESS <= a;
        BYTEENABLE <= 4'hf;
        READ <= 1'b1;
        wait_ack;
        q = READDATA;
        READ <= 1'b0;
        @(posedge CLK);
    endtask
    task bus_wr(input logic [15:0] a, input logic [31:0] v, input logic [3:0] be);
        ADDRESS <= a;
        WRITEDATA <= v;
        BYTEENABLE <= be;
        WRITE <= 1'b1;
        wait_ack;
        WRITE <= 1'b0;
        @(posedge CLK);
    endtask
    // expected decision from shadow config and the frame fields
    function automatic logic [10:0] f_exp(input logic [15:0] v);
        logic [2:0] u, p;
        logic dr;
        u = (tc[7] && v[3:1] > v[6:4]) ? v[6:4] : v[3:1];
        if (ce[1] && v[7]) p = v[10:8];
        else if (ce[2] && v[0]) p = u;
        else if (ce[3] && v[11]) p = v[14:12];
        else p = tc[2:0];
        dr = (tc[4] & ~v[0]) | (tc[3] & v[0]) | (acl_en & ~v[15] & au[0]);
        return {dr, u, p, mp[4*p +: 2], au == 2'h3, acl_en & v[15]};
    endfunction
    // frame scoreboard at mid-cycle where everything is settled
    always @(negedge CLK) begin
        g_frm = {OUT_VALID, OUT_DROP, OUT_UPRI, OUT_PRIO, OUT_QUEUE, OUT_TO_HOST, OUT_ACL_ACT};
        if (!have) g_frm = g_frm & 12'h800; // between frames only valid matters
        e_frm = have ? {1'h1, ex} : 12'h000;
        chk_frm(g_frm, e_frm);
        have = (frm_valid === 1'b1) && !SYS_RST;
        ex = f_exp(fld);
    end
    // hang guard, run needs about 750 cycles
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            $display("MISMATCH %0t timeout", $time);
            end_of_test;
        end
    end
    initial begin
        CLK = 1'h0;
        SYS_RST = 1'h1;
        READ = 1'h0;
        WRITE = 1'h0;
        ADDRESS = 16'h0000;
        BYTEENABLE = 4'h0;
        WRITEDATA = 32'h0;
        go = 1'h0;
        acl_en = 1'h0;
        have = 1'h0;
        tc = 8'h00;
        ce = 8'h00;
        au = 2'h0;
        mp = 32'h33221100;
        cyc = 0;
        fail_count = 0;
        compares = 0;
        al = '{A_CE, A_TAG, A_AUTH, A_PTR};
        repeat (12) @(posedge CLK);
        SYS_RST <= 1'b0;
        @(posedge CLK);
        // reset values
        bus_rd(A_MAP, d);
        chk_reg(d, 32'h33221100);
        for (int i = 0; i < 4; i++) begin
            bus_rd(al[i], d);
            chk_reg(d, 32'h0);
        end
        // pointer fields, reserved bits and a single lane write
        bus_wr(A_PTR, 32'hffffffff, 4'hf);
        bus_rd(A_PTR, d);
        chk_reg(d, 32'h00070003);
        bus_wr(A_PTR, 32'h00020000, 4'h4);
        bus_rd(A_PTR, d);
        chk_reg(d, 32'h00020003);
        chk_reg({27'h0, PORT_INDEX, QUEUE_PTR}, 32'h0000000b);
        // acl enable bit cannot be written
        bus_wr(A_AUTH, 32'h000000ff, 4'h1);
        bus_rd(A_AUTH, d);
        chk_reg(d, 32'h00000003);
        // upper slot bits dropped, only lane 0 slots touched
        bus_wr(A_MAP, 32'hffffffff, 4'h1);
        bus_rd(A_MAP, d);
        chk_reg(d, 32'h33221133);
        bus_rd(16'h2030, d);
        chk_reg(d, 32'h0);
        // every auth code, random config, random traffic
        for (int m = 0; m < 8; m++) begin
            tc = $random(seed);
            ce = $random(seed);
            mp = $random(seed);
            au = m[1:0];
            if (m == 0) tc[4] = 1'b0;
            acl_en <= m[2];
            bus_wr(A_TAG, {24'h0, tc}, 4'h1);
            bus_wr(A_CE, {24'h0, ce}, 4'h1);
            bus_wr(A_AUTH, {30'h0, au}, 4'h1);
            bus_wr(A_MAP, mp, 4'hf);
            mp = mp & 32'h33333333;
            bus_rd(A_TAG, d);
            chk_reg(d, {24'h0, tc & 8'h9f});
            bus_rd(A_CE, d);
            chk_reg(d, {24'h0, ce & 8'h0e});
            bus_rd(A_AUTH, d);
            chk_reg(d, {29'h0, acl_en, au});
            bus_rd(A_MAP, d);
            chk_reg(d, mp);
            go <= 1'b1;
            repeat (60) @(posedge CLK);
            go <= 1'b0;
            repeat (3) @(posedge CLK);
        end
        end_of_test;
    end
endmodule
